// file: rtl/scmd_pkg.sv
/*
 Constants for the single-command record intake: record layout, interrupt
 field layout, status flag positions and the host-side register map.
 Assumes the record is 13 words of 32 bits in host memory, word addressed.
*/
package scmd_pkg;
	// --------------------------------------------------------------
	// Record layout, word indices
	// --------------------------------------------------------------
	localparam int SCMD_WORDS = 13;
	localparam int SCMD_PARAM_WORDS = 7;
	localparam logic [3:0] W_PARAM0 = 4'h0;
	localparam logic [3:0] W_RSVD = 4'h7;
	localparam logic [3:0] W_INTR = 4'h8;
	localparam logic [3:0] W_ST_ID = 4'h9;
	localparam logic [3:0] W_ST_FLAGS = 4'hA;
	localparam logic [3:0] W_ST_INFO0 = 4'hB;
	localparam logic [3:0] W_ST_INFO1 = 4'hC;
	// --------------------------------------------------------------
	// Interrupt field and status flags
	// --------------------------------------------------------------
	localparam int INT_ZERO_LSB = 11;
	localparam int INT_LVL_LSB = 8;
	localparam logic [2:0] INT_LVL_OFF = 3'h0;
	localparam int FLG_BYTE_LSB = 8;
	localparam int FLG_CC = 7;
	localparam int FLG_ERR = 6;
	localparam int FLG_RTY = 5;
	localparam logic [7:0] ERR_RSVD_NONZERO = 8'h01;
	localparam logic RDY_TGL_RST = 1'b0;
	// --------------------------------------------------------------
	// Host-side Wishbone register map, byte addresses
	// --------------------------------------------------------------
	localparam logic [7:0] HR_REC_LAST = 8'h30;
	localparam logic [7:0] HR_CTRL = 8'h40;
	localparam logic [7:0] HR_STAT = 8'h44;
	localparam logic [7:0] HR_VEC = 8'h48;
	localparam int HR_CTRL_ISSUE = 0;
endpackage

// file: rtl/scmd_if.sv
/*
 Link between the host end and the device end of the single-command intake.
 Assumes both ends run on the same clock; no clocking block.
*/
`timescale 1ns/100ps
interface scmd_if;
	// Record issue and readiness
	logic issue;
	logic ready_toggle;
	// Record memory port, served by the host end
	logic mem_req;
	logic mem_we;
	logic [3:0] mem_addr;
	logic [31:0] mem_wdata;
	logic [31:0] mem_rdata;
	logic mem_ack;
	// Interrupt request and acknowledge
	logic [2:0] irq_level;
	logic iack;
	logic [2:0] iack_level;
	logic [7:0] iack_vector;
	logic iack_valid;

	modport dev_mp (
		input issue, mem_rdata, mem_ack, iack, iack_level,
		output ready_toggle, mem_req, mem_we, mem_addr, mem_wdata,
		output irq_level, iack_vector, iack_valid
	);
	modport host_mp (
		output issue, mem_rdata, mem_ack, iack, iack_level,
		input ready_toggle, mem_req, mem_we, mem_addr, mem_wdata,
		input irq_level, iack_vector, iack_valid
	);
endinterface

// file: rtl/scmd_dev.sv
/*
 Device end: fetches the single-command record, checks reserved fields,
 hands the parameters to the executor, writes back the final status block
 and raises the completion interrupt.
 Assumes the host end serves the record memory and runs the acknowledge.
*/
`timescale 1ns/100ps
module scmd_dev
	import scmd_pkg::*;
(
	// Clock, reset, enable
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Link to host end
	scmd_if.dev_mp lnk,
	// Executor request
	output logic exec_valid_o,
	output logic [SCMD_PARAM_WORDS*32-1:0] exec_param_o,
	// Executor result
	input wire logic exec_done_i,
	input wire logic exec_error_i,
	input wire logic [7:0] exec_errcode_i,
	input wire logic exec_recovered_i,
	input wire logic [7:0] exec_retries_i,
	input wire logic [3:0] exec_sense_blocks_i,
	input wire logic [63:0] exec_info_i,
	// Status
	output logic busy_o,
	output logic [15:0] status_blocks_o
);
	// --------------------------------------------------------------
	// State
	// --------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE, ST_FETCH, ST_CHECK, ST_EXEC, ST_STATUS, ST_IRQ, ST_IACK, ST_DONE
	} scmd_st_e;

	typedef struct packed {
		scmd_st_e st;
		logic [SCMD_PARAM_WORDS-1:0][31:0] param;
		logic [31:0] rsvd;
		logic [15:0] intw;
		logic [31:0] rsvd_hi;
		logic [7:0] flags;
		logic [7:0] errcode;
		logic [63:0] info;
		logic [15:0] blocks;
		logic ready_toggle;
		logic [2:0] irq_level;
		logic [7:0] vector;
		logic vec_valid;
		logic exec_valid;
		logic mem_req;
		logic mem_we;
		logic [3:0] mem_addr;
		logic [31:0] mem_wdata;
	} scmd_dev_s;

	scmd_dev_s s;
	scmd_dev_s next_s;

	// --------------------------------------------------------------
	// Helpers
	// --------------------------------------------------------------
	// Status blocks a command produces, from retries and sense size
	function automatic logic [15:0] block_count(input logic recovered,
			input logic [7:0] tries, input logic [3:0] sense);
		logic [15:0] base;
		base = 16'({8'h00, tries} + 16'h0001) * 16'({12'h000, sense});
		if (recovered) begin
			block_count = base + 16'h0001;
		end else begin
			block_count = base;
		end
	endfunction

	// Status write order: identifier, info words, flags last
	function automatic logic [3:0] next_stat_word(input logic [3:0] w);
		case (w)
			W_ST_ID: next_stat_word = W_ST_INFO0;
			W_ST_INFO0: next_stat_word = W_ST_INFO1;
			default: next_stat_word = W_ST_FLAGS;
		endcase
	endfunction

	// Data written to a status word
	function automatic logic [31:0] stat_data(input logic [3:0] w, input scmd_dev_s c);
		case (w)
			W_ST_ID: stat_data = c.param[0];
			W_ST_INFO0: stat_data = c.info[31:0];
			W_ST_INFO1: stat_data = c.info[63:32];
			default: stat_data = {16'h0000, c.flags, c.errcode};
		endcase
	endfunction

	// --------------------------------------------------------------
	// Next-state logic
	// --------------------------------------------------------------
	always_comb begin
		next_s = s;
		next_s.vec_valid = 1'b0;
		case (s.st)
			ST_IDLE: begin
				// Only the record path exists, so the first command after reset uses it
				if (lnk.issue) begin
					next_s.st = ST_FETCH;
					next_s.mem_req = 1'b1;
					next_s.mem_we = 1'b0;
					next_s.mem_addr = W_PARAM0;
				end
			end
			ST_FETCH: begin
				if (lnk.mem_ack) begin
					if (s.mem_addr < W_RSVD) begin
						next_s.param[s.mem_addr[2:0]] = lnk.mem_rdata;
					end
					if (s.mem_addr == W_RSVD) begin
						next_s.rsvd = lnk.mem_rdata;
					end
					if (s.mem_addr == W_INTR) begin
						next_s.intw = lnk.mem_rdata[15:0];
						next_s.rsvd_hi = {16'h0000, lnk.mem_rdata[31:16]};
						next_s.mem_req = 1'b0;
						next_s.st = ST_CHECK;
					end else begin
						next_s.mem_addr = s.mem_addr + 4'h1;
					end
				end
			end
			ST_CHECK: begin
				next_s.flags = 8'h00;
				next_s.errcode = 8'h00;
				next_s.info = 64'h0000_0000_0000_0000;
				next_s.blocks = 16'h0000;
				// Reserved words and the top five interrupt bits must be zero
				if ((s.rsvd != 32'h0000_0000) || (s.rsvd_hi != 32'h0000_0000) ||
						(s.intw[15:INT_ZERO_LSB] != 5'h00)) begin
					next_s.flags[FLG_ERR] = 1'b1;
					next_s.errcode = ERR_RSVD_NONZERO;
					next_s.blocks = 16'h0001;
					next_s.st = ST_STATUS;
					next_s.mem_req = 1'b1;
					next_s.mem_we = 1'b1;
					next_s.mem_addr = W_ST_ID;
				end else begin
					next_s.exec_valid = 1'b1;
					next_s.st = ST_EXEC;
				end
			end
			ST_EXEC: begin
				if (exec_done_i) begin
					next_s.exec_valid = 1'b0;
					next_s.flags[FLG_ERR] = exec_error_i;
					next_s.flags[FLG_RTY] = exec_retries_i != 8'h00;
					next_s.errcode = exec_errcode_i;
					next_s.info = exec_info_i;
					next_s.blocks = block_count(exec_recovered_i, exec_retries_i,
						exec_sense_blocks_i);
					// Earlier blocks are dropped; only the final one goes to memory
					next_s.st = ST_STATUS;
					next_s.mem_req = 1'b1;
					next_s.mem_we = 1'b1;
					next_s.mem_addr = W_ST_ID;
				end
			end
			ST_STATUS: begin
				if (lnk.mem_ack) begin
					if (s.mem_addr == W_ST_FLAGS) begin
						next_s.mem_req = 1'b0;
						next_s.mem_we = 1'b0;
						next_s.st = ST_IRQ;
					end else begin
						next_s.mem_addr = next_stat_word(s.mem_addr);
						if (next_stat_word(s.mem_addr) == W_ST_FLAGS) begin
							next_s.flags[FLG_CC] = 1'b1;
						end
					end
				end
			end
			ST_IRQ: begin
				// Level zero means no interrupt at all
				if (s.intw[INT_LVL_LSB+2:INT_LVL_LSB] == INT_LVL_OFF) begin
					next_s.st = ST_DONE;
				end else begin
					next_s.irq_level = s.intw[INT_LVL_LSB+2:INT_LVL_LSB];
					next_s.st = ST_IACK;
				end
			end
			ST_IACK: begin
				// Answer only an acknowledge for our own level
				if (lnk.iack && (lnk.iack_level == s.irq_level)) begin
					next_s.vector = s.intw[7:0];
					next_s.vec_valid = 1'b1;
					next_s.irq_level = INT_LVL_OFF;
					next_s.st = ST_DONE;
				end
			end
			ST_DONE: begin
				next_s.ready_toggle = ~s.ready_toggle;
				next_s.st = ST_IDLE;
			end
			default: begin
				next_s.st = ST_IDLE;
			end
		endcase
		// Write data tracks the word being written
		next_s.mem_wdata = stat_data(next_s.mem_addr, next_s);
	end

	// --------------------------------------------------------------
	// State register
	// --------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s <= '0;
			s.st <= ST_IDLE;
			s.ready_toggle <= RDY_TGL_RST;
		end else if (ce_i) begin
			s <= next_s;
		end
	end

	// --------------------------------------------------------------
	// Outputs
	// --------------------------------------------------------------
	assign lnk.ready_toggle = s.ready_toggle;
	assign lnk.mem_req = s.mem_req;
	assign lnk.mem_we = s.mem_we;
	assign lnk.mem_addr = s.mem_addr;
	assign lnk.mem_wdata = s.mem_wdata;
	assign lnk.irq_level = s.irq_level;
	assign lnk.iack_vector = s.vector;
	assign lnk.iack_valid = s.vec_valid;
	assign exec_valid_o = s.exec_valid;
	assign exec_param_o = s.param;
	assign busy_o = s.st != ST_IDLE;
	assign status_blocks_o = s.blocks;
endmodule

// file: rtl/scmd_host.sv
/*
 Host end: holds the 13-word record, serves the device's memory port,
 issues the record and runs the interrupt acknowledge. Software reaches
 the record and control registers over classic Wishbone.
 Assumes one clock shared with the device end.
*/
`timescale 1ns/100ps
module scmd_host
	import scmd_pkg::*;
(
	// Clock, reset, enable
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Link to device end
	scmd_if.host_mp lnk,
	// Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o
);
	// --------------------------------------------------------------
	// State
	// --------------------------------------------------------------
	typedef struct packed {
		logic [SCMD_WORDS-1:0][31:0] rec;
		logic [31:0] dat;
		logic ack;
		logic issue;
		logic [31:0] mem_rdata;
		logic mem_ack;
		logic iack;
		logic [2:0] iack_level;
		logic [7:0] vector;
		logic vec_seen;
	} scmd_host_s;

	scmd_host_s s;
	scmd_host_s next_s;
	logic wb_go;

	// Register read mux; unmapped words read zero
	function automatic logic [31:0] rd_mux(input logic [7:0] a, input scmd_host_s c,
			input logic tgl, input logic [2:0] lvl);
		if (a <= HR_REC_LAST) begin
			rd_mux = c.rec[a[5:2]];
		end else if (a == HR_STAT) begin
			rd_mux = {20'h00000, c.iack, lvl, 7'h00, tgl};
		end else if (a == HR_VEC) begin
			rd_mux = {23'h000000, c.vec_seen, c.vector};
		end else begin
			rd_mux = 32'h0000_0000;
		end
	endfunction

	assign wb_go = cyc_i && stb_i && !s.ack;

	// --------------------------------------------------------------
	// Next-state logic
	// --------------------------------------------------------------
	always_comb begin
		next_s = s;
		next_s.ack = wb_go;
		next_s.issue = 1'b0;
		next_s.mem_ack = lnk.mem_req && !s.mem_ack;
		if (wb_go) begin
			next_s.dat = rd_mux(adr_i, s, lnk.ready_toggle, lnk.irq_level);
			if (we_i && (adr_i <= HR_REC_LAST)) begin
				for (int b = 0; b < 4; b++) begin
					if (sel_i[b]) begin
						next_s.rec[adr_i[5:2]][b*8 +: 8] = dat_i[b*8 +: 8];
					end
				end
			end
			if (we_i && (adr_i == HR_CTRL) && sel_i[0]) begin
				next_s.issue = dat_i[HR_CTRL_ISSUE];
			end
		end
		// Device access; its status write wins a clash with software
		if (lnk.mem_req && !s.mem_ack) begin
			next_s.mem_rdata = s.rec[lnk.mem_addr];
			if (lnk.mem_we) begin
				next_s.rec[lnk.mem_addr] = lnk.mem_wdata;
			end
		end
		// Acknowledge cycle for the pending level
		if (!s.iack && (lnk.irq_level != INT_LVL_OFF)) begin
			next_s.iack = 1'b1;
			next_s.iack_level = lnk.irq_level;
		end else if (s.iack && lnk.iack_valid) begin
			next_s.iack = 1'b0;
			next_s.vector = lnk.iack_vector;
			next_s.vec_seen = 1'b1;
		end
	end

	// --------------------------------------------------------------
	// State register
	// --------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s <= '0;
		end else if (ce_i) begin
			s <= next_s;
		end
	end

	// --------------------------------------------------------------
	// Outputs
	// --------------------------------------------------------------
	assign dat_o = s.dat;
	assign ack_o = s.ack;
	assign lnk.issue = s.issue;
	assign lnk.mem_rdata = s.mem_rdata;
	assign lnk.mem_ack = s.mem_ack;
	assign lnk.iack = s.iack;
	assign lnk.iack_level = s.iack_level;
endmodule

// file: verif/scmd_monitor.sv
/*
 Checker on the link between host end and device end of the intake.
 Assumes one clock, synchronous active-high reset, ce_i held high.
*/
`timescale 1ns/100ps
module scmd_monitor
	import scmd_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Link signals
	input wire logic issue,
	input wire logic ready_toggle,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [3:0] mem_addr,
	input wire logic [31:0] mem_wdata,
	input wire logic [31:0] mem_rdata,
	input wire logic mem_ack,
	input wire logic [2:0] irq_level,
	input wire logic iack,
	input wire logic [7:0] iack_vector,
	input wire logic iack_valid
);
	// ----------------------------------------
	// Helper logic
	// ----------------------------------------
	default clocking mon_cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	logic [15:0] intr_q;
	// Interrupt field as fetched, the reference for level and vector
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			intr_q <= 16'h0;
		end else if (mem_req && mem_ack && !mem_we && mem_addr == W_INTR) begin
			intr_q <= mem_rdata[15:0];
		end
	end
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	mem_req_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr)
		&& $stable(mem_we) && $stable(mem_wdata)) else $error("memory request changed early");
	mem_ack_time_a: assert property (mem_req && !mem_ack |=> mem_ack)
		else $error("memory answer late");
	mem_ack_pulse_a: assert property (mem_ack |=> !mem_ack) else $error("memory ack too long");
	flags_last_a: assert property (mem_req && mem_we && mem_ack && mem_addr == W_ST_INFO1
		|=> ##[0:3] mem_req && mem_we && mem_addr == W_ST_FLAGS) else $error("flags not last");
	flags_done_a: assert property (mem_req && mem_we && mem_addr == W_ST_FLAGS
		|-> mem_wdata[FLG_BYTE_LSB+FLG_CC]) else $error("status written without done flag");
	irq_level_a: assert property (irq_level != 3'h0 |-> irq_level == intr_q[10:8])
		else $error("interrupt level differs from field");
	iack_answer_a: assert property ($rose(iack) |-> ##[1:3] iack_valid)
		else $error("acknowledge not answered");
	iack_vector_a: assert property (iack_valid |-> iack_vector == intr_q[7:0])
		else $error("acknowledge vector wrong");
	irq_drop_a: assert property (iack_valid |=> irq_level == 3'h0)
		else $error("interrupt held after acknowledge");
	ready_flip_a: assert property (iack_valid |-> ##[1:3] $changed(ready_toggle))
		else $error("readiness did not flip");
	ready_reset_a: assert property ($fell(rst_i) |-> ready_toggle == RDY_TGL_RST)
		else $error("readiness not cleared by reset");
	// Main scenarios
	issue_c: cover property (issue);
	iack_c: cover property (iack_valid);
	flip_c: cover property ($changed(ready_toggle));
endmodule

// file: verif/single_command_intake_tb.sv
/*
 Testbench for both ends of the intake joined by the link interface.
 Assumes Wishbone answers within a bounded wait and ce_i stays high.
*/
`timescale 1ns/100ps
module single_command_intake_tb
	import scmd_pkg::*;
;
	// ----------------------------------------
	// Signals and instances
	// ----------------------------------------
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, exec_valid, busy;
	logic [7:0] adr = 8'h0;
	logic [31:0] wdat = 32'h0, rdat;
	logic done = 1'b0, ex_err = 1'b0, ex_rec = 1'b0, exec_seen, irq_seen;
	logic [7:0] ex_code = 8'h0, ex_rty = 8'h0;
	logic [3:0] ex_sns = 4'h0;
	logic [63:0] ex_info = 64'h0;
	logic [223:0] param;
	logic [15:0] blocks;
	int fail_count = 0;
	int comparisons = 0;
	always #4 clk_i = ~clk_i;
	scmd_if scmd_if_i();
	scmd_host scmd_host_i(.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .lnk(scmd_if_i.host_mp),
		.cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(wdat),
		.dat_o(rdat), .ack_o(ack));
	scmd_dev scmd_dev_i(.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .lnk(scmd_if_i.dev_mp),
		.exec_valid_o(exec_valid), .exec_param_o(param), .exec_done_i(done),
		.exec_error_i(ex_err), .exec_errcode_i(ex_code), .exec_recovered_i(ex_rec),
		.exec_retries_i(ex_rty), .exec_sense_blocks_i(ex_sns), .exec_info_i(ex_info),
		.busy_o(busy), .status_blocks_o(blocks));
	scmd_monitor scmd_monitor_i(.clk_i(clk_i), .rst_i(rst_i), .issue(scmd_if_i.issue),
		.ready_toggle(scmd_if_i.ready_toggle), .mem_req(scmd_if_i.mem_req),
		.mem_we(scmd_if_i.mem_we), .mem_addr(scmd_if_i.mem_addr),
		.mem_wdata(scmd_if_i.mem_wdata), .mem_rdata(scmd_if_i.mem_rdata),
		.mem_ack(scmd_if_i.mem_ack), .irq_level(scmd_if_i.irq_level), .iack(scmd_if_i.iack),
		.iack_vector(scmd_if_i.iack_vector), .iack_valid(scmd_if_i.iack_valid));
	// Seen-flags for things that must or must not happen during a command
	always @(posedge clk_i) begin
		if (exec_valid === 1'b1) exec_seen = 1'b1;
		if (scmd_if_i.irq_level !== 3'h0) irq_seen = 1'b1;
	end
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic conclude();
		$display("fail_count %0d comparisons %0d", fail_count, comparisons);
		if (fail_count == 0 && comparisons > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Classic cycle; request held until ack is sampled high, only the watchdog ends a hang
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk_i);
		end while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	// Polls a flag at clock edges with a bound
	task automatic wait_for(ref logic s, input logic v, input int lim);
		int n;
		n = 0;
		while (s !== v && n < lim) begin
			@(posedge clk_i);
			n++;
		end
		// A wait that runs out is a mismatch, not a silent pass
		if (s !== v) begin
			fail_count++;
			$display("mismatch wait expected %b seen %b", v, s);
		end
	endtask
	task automatic run_cmd(input logic [2:0] lvl, input logic rsv, input logic rec,
		input logic [7:0] rty, input logic [3:0] sns, input logic er);
		logic [31:0] d, t0;
		logic [7:0] ec, v;
		logic [15:0] nb;
		v = {5'h15, lvl};
		ec = rsv ? ERR_RSVD_NONZERO : (er ? 8'h2A : 8'h00);
		nb = rsv ? 16'h1 : (16'(rty) + 16'h1) * 16'(sns) + 16'(rec);
		ex_err <= er;
		ex_code <= ec;
		ex_rec <= rec;
		ex_rty <= rty;
		ex_sns <= sns;
		ex_info <= {16'h1C1C, 13'h0, lvl, 16'h2D2D, 13'h0, lvl};
		for (int i = 0; i < 13; i++) wb(1'b1, 8'(i * 4), (i < 7) ? 32'hA500_0000 + i : 0, d);
		if (rsv) wb(1'b1, 8'h1C, 32'h0000_0100, d);
		wb(1'b1, 8'h20, {16'h0, 5'h0, lvl, v}, d);
		wb(1'b0, HR_STAT, 32'h0, t0);
		exec_seen = 1'b0;
		irq_seen = 1'b0;
		wb(1'b1, HR_CTRL, 32'h1, d);
		wait_for(busy, 1'b1, 20);
		if (!rsv) begin
			wait_for(exec_valid, 1'b1, 200);
			chk("param", 32'hA500_0006, param[223:192]);
			done <= 1'b1;
			@(posedge clk_i);
			done <= 1'b0;
		end
		wait_for(busy, 1'b0, 400);
		repeat (2) @(posedge clk_i);
		chk("exec", {31'h0, !rsv}, {31'h0, exec_seen});
		wb(1'b0, 8'h24, 32'h0, d);
		chk("id", 32'hA500_0000, d);
		wb(1'b0, 8'h28, 32'h0, d);
		chk("flags", {16'h0, 1'b1, rsv | er, !rsv && rty != 0, 5'h0, ec}, d);
		wb(1'b0, 8'h2C, 32'h0, d);
		chk("info low", rsv ? 32'h0 : {16'h2D2D, 13'h0, lvl}, d);
		wb(1'b0, 8'h30, 32'h0, d);
		chk("info high", rsv ? 32'h0 : {16'h1C1C, 13'h0, lvl}, d);
		chk("blocks", {16'h0, nb}, {16'h0, blocks});
		chk("irq", {31'h0, lvl != 0}, {31'h0, irq_seen});
		wb(1'b0, HR_STAT, 32'h0, d);
		chk("ready", {31'h0, ~t0[0]}, {31'h0, d[0]});
		if (lvl != 0) begin
			wb(1'b0, HR_VEC, 32'h0, d);
			chk("vector", {23'h0, 1'b1, v}, d);
		end
	endtask
	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial begin
		logic [31:0] d;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, HR_STAT, 32'h0, d);
		chk("ready reset", 32'h0, d);
		wb(1'b1, HR_REC_LAST, 32'hC3C3_5A5A, d);
		wb(1'b0, HR_REC_LAST, 32'h0, d);
		chk("last word", 32'hC3C3_5A5A, d);
		wb(1'b1, 8'h80, 32'hFFFF_FFFF, d);
		wb(1'b0, 8'h80, 32'h0, d);
		chk("unmapped", 32'h0, d);
		// Every level code, with retry, recovery, error and reserved cases mixed in
		for (int l = 0; l < 8; l++) run_cmd(3'(l), l == 7, l[0], 8'(l), 4'(l + 1), l == 5);
		// Odd command count leaves readiness high, so a mid-run reset must clear it
		run_cmd(3'h3, 1'b0, 1'b1, 8'h0, 4'h1, 1'b0);
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, HR_STAT, 32'h0, d);
		chk("ready mid reset", 32'h0, d);
		conclude();
	end
	initial begin
		repeat (30000) @(posedge clk_i);
		fail_count++;
		conclude();
	end
endmodule
